//--- src/lec_params.svh
// Register map, field positions, reset values and timing counts of the line encoder
// Overview of operation
// - E3 single-rail: four zeros become 000V or B00V
// - Odd pulse count between successive violations
// - DS3/STS-1: three zeros become B0V or 00V
// - Control bit 0 or pin selects single-rail
// - Dual-rail bypasses encoder
// - Single-rail input violations become plain pulses
// - Build-out enabled when select is 0
// - E3 rate forces build-out off
// - Fault flag low while transitions seen
// - Fault high after 128 idle clocks
// - Transmitter on by pin, or bit plus pin
// - Transmitter off tri-states both line outputs
// - Host bit hands on/off to pin
// - Equalizer in when control is 1
// - Monitor bit adds 20 dB gain stage
// - Monitor mode suppresses loss-of-signal entirely
`ifndef LEC_PARAMS_SVH
`define LEC_PARAMS_SVH
`define LEC_CTRL_OFF    8'h00
`define LEC_STAT_OFF    8'h04
`define LEC_CTRL_MASK   32'h0000_007f
`define LEC_CTRL_RST    32'h0000_0008
`define LEC_B_SINGLE    0
`define LEC_B_BOSEL     1
`define LEC_B_TXON      2
`define LEC_B_EQ        3
`define LEC_B_MON       4
`define LEC_B_RATE      5
`define LEC_DM_PERIODS  128
`define LEC_DM_TOL      32
`define LEC_ZMAX_HDB3   3
`define LEC_ZMAX_B3ZS   2
`endif

//--- src/lec_pkg.sv
// Types shared by the line encoder modules
package lec_pkg;
  typedef enum logic [1:0] {
    LEC_SYM_ZERO = 2'h0,
    LEC_SYM_MARK = 2'h1,
    LEC_SYM_V    = 2'h2,
    LEC_SYM_B    = 2'h3
  } lec_sym_t;
  typedef enum logic [1:0] {
    LEC_RATE_E3   = 2'h0,
    LEC_RATE_DS3  = 2'h1,
    LEC_RATE_STS1 = 2'h2
  } lec_rate_t;
endpackage : lec_pkg

//--- src/lec_encoder.sv
// HDB3/B3ZS zero-substitution encoder with dual-rail bypass
`timescale 1ns/100ps
module lec_encoder
  import lec_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic strobe,
  input  wire logic single,
  input  wire logic e3,
  input  wire logic in_pos,
  input  wire logic in_neg,
  output logic      out_pos,
  output logic      out_neg
);
  lec_sym_t slot_q [4];
  lec_sym_t slot_d [4];
  lec_sym_t tap;
  logic     last_pol_q;
  logic     parity_q;
  logic     new_bit;
  logic     run_zero;
  logic     pulse;
  logic     pol;

  always_comb begin
    tap      = e3 ? slot_q[3] : slot_q[2];
    pulse    = (tap != LEC_SYM_ZERO);
    pol      = (tap == LEC_SYM_V) ? last_pol_q : ~last_pol_q;
    new_bit  = in_pos | in_neg;
    run_zero = !new_bit && slot_q[0] == LEC_SYM_ZERO && slot_q[1] == LEC_SYM_ZERO
               && (!e3 || slot_q[2] == LEC_SYM_ZERO);
    slot_d[0] = new_bit ? LEC_SYM_MARK : (run_zero ? LEC_SYM_V : LEC_SYM_ZERO);
    slot_d[1] = slot_q[0];
    slot_d[2] = slot_q[1];
    slot_d[3] = slot_q[2];
    // Parity after this strobe's output decides the pattern
    if (run_zero && (tap == LEC_SYM_V || !(parity_q ^ pulse))) begin
      if (e3)
        slot_d[3] = LEC_SYM_B;
      else
        slot_d[2] = LEC_SYM_B;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= '{default: LEC_SYM_ZERO};
    end else if (strobe) begin
      if (single)
        slot_q <= slot_d;
      else
        slot_q <= '{default: LEC_SYM_ZERO};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pol_q <= 1'b0;
      parity_q   <= 1'b0;
    end else if (strobe && single && pulse) begin
      last_pol_q <= pol;
      parity_q   <= (tap == LEC_SYM_V) ? 1'b0 : ~parity_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pos <= 1'b0;
      out_neg <= 1'b0;
    end else if (strobe) begin
      out_pos <= single ? (pulse & pol) : in_pos;
      out_neg <= single ? (pulse & ~pol) : in_neg;
    end
  end
endmodule : lec_encoder

//--- src/lec_drive_monitor.sv
// Idle-line watchdog counting transmit clock periods between line transitions
`timescale 1ns/100ps
`include "lec_params.svh"
module lec_drive_monitor #(
  parameter logic [7:0] THRESH = 8'(`LEC_DM_PERIODS)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  input  wire logic trans,
  output logic      fault
);
  logic [7:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      fault <= 1'b0;
    end else if (trans) begin
      cnt_q <= 8'h00;
      fault <= 1'b0;
    end else if (tick && cnt_q != THRESH) begin
      cnt_q <= cnt_q + 8'h01;
      fault <= (cnt_q == THRESH - 8'h01);
    end
  end
endmodule : lec_drive_monitor

//--- src/lec_top.sv
// Transmit-side line coding, driver control and receiver gain control with APB access
`timescale 1ns/100ps
`include "lec_params.svh"
module lec_top
  import lec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        transmit_line_clock,
  input  wire logic        positive_tx_data,
  input  wire logic        negative_tx_data,
  input  wire logic        monitor_in_pos,
  input  wire logic        monitor_in_neg,
  input  wire logic        host_mode,
  input  wire logic        rail_format_select,
  input  wire logic        build_out_select,
  input  wire logic        transmitter_enable,
  input  wire logic        equalizer_enable,
  input  wire logic        monitor_gain_enable,
  input  wire logic [1:0]  rate_select,
  input  wire logic        los_detect_in,
  output logic             line_out_pos,
  output logic             line_out_pos_oe,
  output logic             line_out_neg,
  output logic             line_out_neg_oe,
  output logic             drive_fault_flag,
  output logic             build_out_active,
  output logic             equalizer_on,
  output logic             monitor_gain_on,
  output logic             los_out
);
  localparam int SW = 14;

  // Synchronisers for every pin from outside the pclk domain
  logic [SW-1:0] async_in;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;

  assign async_in = {los_detect_in, rate_select, host_mode, monitor_gain_enable,
                     equalizer_enable, transmitter_enable, build_out_select,
                     rail_format_select, monitor_in_neg, monitor_in_pos,
                     negative_tx_data, positive_tx_data, transmit_line_clock};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  logic       clk_s;
  logic       pos_s;
  logic       neg_s;
  logic       mpos_s;
  logic       mneg_s;
  logic       rail_s;
  logic       bos_s;
  logic       txen_s;
  logic       eq_s;
  logic       mon_s;
  logic       host_s;
  lec_rate_t  rate_s;
  logic       los_s;

  assign clk_s  = s2_q[0];
  assign pos_s  = s2_q[1];
  assign neg_s  = s2_q[2];
  assign mpos_s = s2_q[3];
  assign mneg_s = s2_q[4];
  assign rail_s = s2_q[5];
  assign bos_s  = s2_q[6];
  assign txen_s = s2_q[7];
  assign eq_s   = s2_q[8];
  assign mon_s  = s2_q[9];
  assign host_s = s2_q[10];
  assign rate_s = lec_rate_t'(s2_q[12:11]);
  assign los_s  = s2_q[13];

  // Edge finders on the synchronised line clock and monitor inputs
  logic clk_prev_q;
  logic mpos_prev_q;
  logic mneg_prev_q;
  logic strobe;
  logic trans;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q  <= 1'b0;
      mpos_prev_q <= 1'b0;
      mneg_prev_q <= 1'b0;
    end else begin
      clk_prev_q  <= clk_s;
      mpos_prev_q <= mpos_s;
      mneg_prev_q <= mneg_s;
    end
  end

  assign strobe = clk_s & ~clk_prev_q;
  assign trans  = (mpos_s ^ mpos_prev_q) | (mneg_s ^ mneg_prev_q);

  // APB slave: one wait-free access phase, pready from a flop
  logic [31:0] ctrl_q;
  logic [31:0] status;
  logic        setup;
  logic        access;
  logic        addr_bad;

  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready;
  assign addr_bad = !(paddr == `LEC_CTRL_OFF || paddr == `LEC_STAT_OFF)
                    || (pwrite && paddr == `LEC_STAT_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & addr_bad;
      if (setup && !pwrite) begin
        case (paddr)
          `LEC_CTRL_OFF: prdata <= ctrl_q;
          `LEC_STAT_OFF: prdata <= status;
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= `LEC_CTRL_RST;
    else if (access && pwrite && !pslverr && paddr == `LEC_CTRL_OFF)
      ctrl_q <= pwdata & `LEC_CTRL_MASK;
  end

  // Effective controls: host mode takes register bits (transmit enable needs bit and pin), hardware mode the pins
  logic      single_eff;
  logic      bos_eff;
  logic      eq_eff;
  logic      mon_eff;
  logic      tx_on;
  lec_rate_t rate_eff;
  logic      e3;

  always_comb begin
    single_eff = host_s ? ctrl_q[`LEC_B_SINGLE] : rail_s;
    bos_eff    = host_s ? ctrl_q[`LEC_B_BOSEL] : bos_s;
    eq_eff     = host_s ? ctrl_q[`LEC_B_EQ] : eq_s;
    mon_eff    = host_s ? ctrl_q[`LEC_B_MON] : mon_s;
    // A host bit of 1 defers to the pin so a spare card can switch in fast
    tx_on      = txen_s & (!host_s | ctrl_q[`LEC_B_TXON]);
    rate_eff   = host_s ? lec_rate_t'(ctrl_q[`LEC_B_RATE+1:`LEC_B_RATE]) : rate_s;
    e3         = (rate_eff == LEC_RATE_E3);
  end

  // Encoder and idle-line watchdog
  logic enc_pos;
  logic enc_neg;
  logic dm_fault;

  lec_encoder u_enc (
    .pclk    (pclk),
    .presetn (presetn),
    .strobe  (strobe),
    .single  (single_eff),
    .e3      (e3),
    .in_pos  (pos_s),
    .in_neg  (neg_s),
    .out_pos (enc_pos),
    .out_neg (enc_neg)
  );

  lec_drive_monitor u_dm (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (strobe),
    .trans   (trans),
    .fault   (dm_fault)
  );

  // Output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out_pos    <= 1'b0;
      line_out_neg    <= 1'b0;
      line_out_pos_oe <= 1'b0;
      line_out_neg_oe <= 1'b0;
    end else begin
      line_out_pos    <= tx_on & enc_pos;
      line_out_neg    <= tx_on & enc_neg;
      line_out_pos_oe <= tx_on;
      line_out_neg_oe <= tx_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      build_out_active <= 1'b0;
      equalizer_on     <= 1'b0;
      monitor_gain_on  <= 1'b0;
      los_out          <= 1'b0;
      drive_fault_flag <= 1'b0;
    end else begin
      build_out_active <= !bos_eff && !e3;
      equalizer_on     <= eq_eff;
      monitor_gain_on  <= mon_eff;
      los_out          <= los_s && !mon_eff;
      drive_fault_flag <= dm_fault;
    end
  end

  assign status = {27'h0, single_eff, mon_eff, build_out_active, tx_on, drive_fault_flag};

  // Checking helpers: output zero runs and pulses between violations
  logic       strb_d_q;
  logic [2:0] warm_q;
  logic [2:0] zrun_q;
  logic       par_q;
  logic       seen_v_q;
  logic       lpol_q;
  logic       is_v;
  logic       any_p;

  assign any_p = enc_pos | enc_neg;
  assign is_v  = any_p && (enc_pos == lpol_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strb_d_q <= 1'b0;
      warm_q   <= 3'h0;
      zrun_q   <= 3'h0;
      par_q    <= 1'b0;
      seen_v_q <= 1'b0;
      lpol_q   <= 1'b0;
    end else begin
      strb_d_q <= strobe;
      if (!single_eff || $changed(e3)) begin
        warm_q   <= 3'h0;
        zrun_q   <= 3'h0;
        seen_v_q <= 1'b0;
      end else if (strb_d_q) begin
        if (warm_q != 3'h7)
          warm_q <= warm_q + 3'h1;
        zrun_q <= any_p ? 3'h0 : ((zrun_q == 3'h7) ? zrun_q : zrun_q + 3'h1);
        if (any_p) begin
          lpol_q   <= enc_pos;
          par_q    <= is_v ? 1'b0 : ~par_q;
          seen_v_q <= seen_v_q | is_v;
        end
      end
    end
  end

  a_hdb3_zero_run: assert property (@(posedge pclk) disable iff (!presetn)
    (warm_q == 3'h7 && e3) |-> zrun_q <= 3'(`LEC_ZMAX_HDB3))
    else $error("HDB3 output holds four zeros");
  a_b3zs_zero_run: assert property (@(posedge pclk) disable iff (!presetn)
    (warm_q == 3'h7 && !e3) |-> zrun_q <= 3'(`LEC_ZMAX_B3ZS))
    else $error("B3ZS output holds three zeros");
  a_v_odd_pulses: assert property (@(posedge pclk) disable iff (!presetn)
    (strb_d_q && single_eff && seen_v_q && is_v && warm_q == 3'h7) |-> par_q)
    else $error("Even pulse count between violations");
  a_dual_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && !single_eff) |=> (enc_pos == $past(pos_s) && enc_neg == $past(neg_s)))
    else $error("Dual-rail data not passed through");
  a_single_mark: assert property (@(posedge pclk) disable iff (!presetn)
    !(enc_pos && enc_neg && $past(single_eff, 2)))
    else $error("Both rails driven in single-rail");
  a_off_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_on |=> !line_out_pos_oe && !line_out_neg_oe && !line_out_pos)
    else $error("Line driven while transmitter off");
  a_host_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (host_s && !txen_s) ##1 1'b1 |-> !line_out_pos_oe)
    else $error("Pin low did not stop transmitter");
  a_hw_pin_on: assert property (@(posedge pclk) disable iff (!presetn)
    (!host_s && txen_s) |=> line_out_neg_oe)
    else $error("Pin high did not start transmitter");
  a_e3_no_bo: assert property (@(posedge pclk) disable iff (!presetn)
    e3 |=> !build_out_active)
    else $error("Build-out active at E3 rate");
  a_bo_sel_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!e3 && !bos_eff) |=> build_out_active)
    else $error("Build-out off with select low");
  a_mon_no_los: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_eff && los_s) |=> (!los_out && monitor_gain_on))
    else $error("Loss of signal seen in monitor mode");
  a_eq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(eq_eff) |=> equalizer_on == $past(eq_eff))
    else $error("Equalizer does not follow control");
  a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
    trans |-> ##2 !drive_fault_flag)
    else $error("Fault flag high after transition");
  a_fault_window: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(drive_fault_flag) |-> u_dm.cnt_q >= 8'(`LEC_DM_PERIODS - `LEC_DM_TOL))
    else $error("Fault flag raised too early");
endmodule : lec_top

//--- testbench/lec_framer_model.sv
// Framer model: transmit line clock, data pattern and monitor tap
`timescale 1ns/100ps
module lec_framer_model (
  input  wire logic        run,
  input  wire logic        single,
  input  wire logic        loop,
  input  wire logic [63:0] pos_pat,
  input  wire logic [63:0] neg_pat,
  input  wire logic        lo_pos,
  input  wire logic        lo_neg,
  input  wire logic        lo_oe,
  output logic             line_clk,
  output logic             tx_pos,
  output logic             tx_neg,
  output logic             mon_pos,
  output logic             mon_neg
);
  logic [5:0] idx;
  initial begin
    line_clk = 1'b0;
    idx      = 6'h00;
    tx_pos   = 1'b0;
    tx_neg   = 1'b0;
    #7;
    forever begin
      #80;
      line_clk = run ? ~line_clk : 1'b0;
    end
  end
  // New bit on the falling edge so it is stable across the sampling rise
  always @(negedge line_clk) begin
    tx_pos <= pos_pat[idx];
    tx_neg <= single ? 1'b0 : neg_pat[idx];
    idx    <= idx + 6'h01;
  end
  // A released line floats, so show a moving level rather than a stale one
  assign mon_pos = loop & (lo_oe ? lo_pos : line_clk);
  assign mon_neg = loop & (lo_oe ? lo_neg : ~line_clk);
endmodule : lec_framer_model

//--- testbench/tb_top.sv
// Self-checking bench: APB control, line coding and drive monitor
`timescale 1ns/100ps
`include "lec_params.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        host_mode, rail_format_select, build_out_select, transmitter_enable;
  logic        equalizer_enable, monitor_gain_enable, los_detect_in;
  logic [1:0]  rate_select;
  logic        transmit_line_clock, positive_tx_data, negative_tx_data;
  logic        monitor_in_pos, monitor_in_neg;
  logic        line_out_pos, line_out_pos_oe, line_out_neg, line_out_neg_oe;
  logic        drive_fault_flag, build_out_active, equalizer_on, monitor_gain_on, los_out;
  logic        er, run, loop, sgl, obs, par, have, last, seen_v;
  logic [63:0] pos_pat;
  int          fails, n_tests, since, zrun, maxz, npos, nneg, nviol, k;
  int          enc = (1 << `LEC_B_SINGLE) | (1 << `LEC_B_TXON);

  lec_top i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .transmit_line_clock, .positive_tx_data, .negative_tx_data, .monitor_in_pos,
    .monitor_in_neg, .host_mode, .rail_format_select, .build_out_select, .transmitter_enable,
    .equalizer_enable, .monitor_gain_enable, .rate_select, .los_detect_in, .line_out_pos,
    .line_out_pos_oe, .line_out_neg, .line_out_neg_oe, .drive_fault_flag, .build_out_active,
    .equalizer_on, .monitor_gain_on, .los_out
  );
  lec_framer_model i_fr (
    .run, .single(sgl), .loop, .pos_pat, .neg_pat(64'h0), .lo_pos(line_out_pos),
    .lo_neg(line_out_neg), .lo_oe(line_out_pos_oe), .line_clk(transmit_line_clock),
    .tx_pos(positive_tx_data), .tx_neg(negative_tx_data), .mon_pos(monitor_in_pos),
    .mon_neg(monitor_in_neg)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Returns on a pclk edge so callers may drive inputs straight away
  task wait_line(input int n);
    repeat (n) @(posedge transmit_line_clock);
    @(posedge pclk);
  endtask : wait_line

  task start_obs(input logic p);
    par = p;
    {have, seen_v} = 2'b0;
    {since, zrun, maxz, npos, nneg, nviol} = '0;
    obs = 1'b1;
  endtask : start_obs

  // Output settles well within one bit, so sample at the next line clock rise
  always @(posedge transmit_line_clock) begin
    if (obs) begin
      if (line_out_pos | line_out_neg) begin
        if (have && line_out_pos == last) begin
          nviol++;
          if (par && seen_v) chk(since % 2, 1);
          since = 0;
          seen_v = 1'b1;
        end else begin
          since++;
        end
        npos += line_out_pos;
        nneg += line_out_neg;
        last = line_out_pos;
        have = 1'b1;
        zrun = 0;
      end else if (have) begin
        zrun++;
        if (zrun > maxz) maxz = zrun;
      end
    end
  end

  initial begin
    #1000000;
    fails++;
    close_out();
  end

  initial begin
    {fails, n_tests} = '0;
    {presetn, obs, run, loop, sgl} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rail_format_select, build_out_select, equalizer_enable, monitor_gain_enable} = '0;
    rate_select = 2'h0;
    {host_mode, transmitter_enable, los_detect_in} = 3'h7;
    pos_pat = 64'h0000_0001_0000_00b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LEC_CTRL_OFF, 32'h0);
    chk(rd, `LEC_CTRL_RST);
    apb(1'b0, `LEC_STAT_OFF, 32'h0);
    chk(equalizer_on, 1'b1);
    chk({er, rd[30:0]}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `LEC_STAT_OFF, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b1, `LEC_CTRL_OFF, 32'hffff_ffff);
    apb(1'b0, `LEC_CTRL_OFF, 32'h0);
    chk(rd, `LEC_CTRL_MASK);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `LEC_CTRL_OFF, (i / 2) << `LEC_B_RATE | (i % 2) << `LEC_B_BOSEL
          | (1 - i % 2) << `LEC_B_EQ | (i % 2) << `LEC_B_MON);
      repeat (8) @(posedge pclk);
      chk(build_out_active, i > 1 && i % 2 == 0);
      chk(equalizer_on, 1 - i % 2);
      chk(monitor_gain_on, i % 2);
      chk(los_out, 1 - i % 2);
    end
    for (int i = 0; i < 5; i++) begin
      host_mode          <= i < 3;
      transmitter_enable <= i != 2 && i != 4;
      apb(1'b1, `LEC_CTRL_OFF, 32'(i == 1 || i == 2) << `LEC_B_TXON);
      repeat (8) @(posedge pclk);
      chk({line_out_pos_oe, line_out_neg_oe}, (i == 1 || i == 3) ? 2'h3 : 2'h0);
    end
    rate_select         <= 2'h1;
    monitor_gain_enable <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(build_out_active, 1'b1);
    chk(equalizer_on, 1'b0);
    chk(monitor_gain_on, 1'b1);
    chk(los_out, 1'b0);
    host_mode <= 1'b1;
    // Last pass of the enable loop left the pin low; coding checks need a live line
    transmitter_enable <= 1'b1;
    run       <= 1'b1;
    sgl       <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, `LEC_CTRL_OFF, 32'(r) << `LEC_B_RATE | enc);
      wait_line(12);
      start_obs(1'b1);
      wait_line(130);
      obs = 1'b0;
      chk(maxz <= (r == 0 ? `LEC_ZMAX_HDB3 : `LEC_ZMAX_B3ZS), 1);
      chk(nviol > 0 && npos > 0 && nneg > 0, 1);
    end
    sgl     <= 1'b0;
    pos_pat <= 64'hffff_0000_0000_0000;
    apb(1'b1, `LEC_CTRL_OFF, 1 << `LEC_B_TXON);
    wait_line(12);
    start_obs(1'b0);
    wait_line(130);
    obs = 1'b0;
    chk({nneg == 0, npos > 0, maxz >= 40}, 3'h7);
    sgl     <= 1'b1;
    pos_pat <= 64'h0000_0001_0000_00b0;
    loop    <= 1'b1;
    apb(1'b1, `LEC_CTRL_OFF, enc);
    wait_line(40);
    chk(drive_fault_flag, 1'b0);
    loop <= 1'b0;
    wait_line(95);
    chk(drive_fault_flag, 1'b0);
    k = 0;
    while (drive_fault_flag !== 1'b1 && k < 64) begin
      wait_line(1);
      k++;
    end
    chk(drive_fault_flag, 1'b1);
    apb(1'b0, `LEC_STAT_OFF, 32'h0);
    chk(rd[0], 1'b1);
    loop <= 1'b1;
    wait_line(6);
    chk(drive_fault_flag, 1'b0);
    close_out();
  end
endmodule : tb_top
